/* File: adcc_top.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_top
   import adcc_pkg::*;
(
   input  wire logic        pclk,        // Bus clock, 20 MHz
   input  wire logic        presetn,     // Async reset, low
   input  wire logic        psel,        // APB select
   input  wire logic        penable,     // APB enable
   input  wire logic        pwrite,      // APB direction
   input  wire logic [11:0] paddr,       // APB byte address
   input  wire logic [31:0] pwdata,      // APB write data
   output logic      [31:0] prdata,      // APB read data
   output logic             pready,      // APB ready
   output logic             pslverr,     // APB error, unmapped
   input  wire logic        halt_mode,   // Core in halt
   input  wire logic        comp_in,     // Comparator, input above trial
   output logic             adc_enable,  // Analog core powered
   output logic      [3:0]  channel_sel, // Input multiplexer select
   output logic      [9:0]  dac_code,    // Trial word to the DAC
   output logic             sample_hold  // Sample switch closed
);
   localparam int unsigned SW          = $clog2(WAKE_SETTLE_CYC + 1);
   localparam logic [SW-1:0] SETTLE_LOAD = SW'(WAKE_SETTLE_CYC);
   localparam logic [2:0]  SAMPLE_LAST = 3'(SAMPLE_TICKS - 1);
   localparam logic [2:0]  STEP_LAST   = 3'(STEP_TICKS - 1);
   localparam logic [3:0]  MSB_IDX     = 4'(RES_BITS - 1);

   // ***************************************************
   // Helpers
   // ***************************************************
   function automatic adcc_hit_type reg_hit(input logic [11:0] a);
      case (a[11:2])
         IDX_CONTROL_STATUS: return HIT_CSR;
         IDX_RESULT_HIGH:    return HIT_HIGH;
         IDX_RESULT_LOW:     return HIT_LOW;
         default:            return HIT_NONE;
      endcase
   endfunction

   function automatic logic [9:0] bit_mask(input logic [3:0] i);
      return 10'h001 << i;
   endfunction

   // ***************************************************
   // Declarations
   // ***************************************************
   adcc_state_type state_q, state_d;
   logic           eoc_q, eoc_d;
   logic           speed_q, speed_d;
   logic           converter_on_q, converter_on_d;
   logic           full_q, full_d;
   logic [3:0]     ch_q, ch_d;
   logic [9:0]     result_q, result_d;
   logic [31:0]    prdata_q, prdata_d;
   logic           pready_q, pready_d;
   logic           pslverr_q, pslverr_d;
   logic [2:0]     tcnt_q, tcnt_d;
   logic [3:0]     bit_q, bit_d;
   logic [9:0]     trial_q, trial_d;
   logic           sh_q, sh_d;
   logic           pwr_q, pwr_d;
   logic [SW-1:0]  settle_q, settle_d;
   logic [2:0]     comp_s_q;
   logic           comp_f_q, comp_f_d;
   adcc_hit_type   hit;
   logic           setup_acc, done_acc, wr_csr, rd_high, rd_hold;
   logic           ch_change, abort, restart, tick;
   logic [3:0]     wdata_ch;
   logic [9:0]     decided;
   logic           buf_in_valid, buf_in_ready, buf_out_valid, buf_out_ready, drain;
   logic [9:0]     buf_out_data;

   // ***************************************************
   // APB decode
   // ***************************************************
   assign hit       = reg_hit(paddr);
   assign setup_acc = psel & penable & ~pready_q;
   assign done_acc  = psel & penable & pready_q;
   assign wr_csr    = done_acc & pwrite & (hit == HIT_CSR);
   assign rd_high   = done_acc & ~pwrite & (hit == HIT_HIGH);
   assign rd_hold   = psel & penable & ~pwrite & ((hit == HIT_HIGH) | (hit == HIT_LOW));
   assign wdata_ch  = pwdata[CSR_CH_LSB +: 4];
   assign ch_change = wr_csr & (wdata_ch != ch_q) & (state_q != ST_OFF);
   // stop on converter-off; halt stops too; wait has no effect
   assign abort     = (state_q != ST_OFF) & (~converter_on_d | halt_mode | ch_change);
   assign restart   = ch_change & converter_on_d & ~halt_mode;

   // ***************************************************
   // Registers and bus answer
   // ***************************************************
   always_comb
   begin
      pready_d  = setup_acc;
      pslverr_d = setup_acc & (hit == HIT_NONE);
      prdata_d  = 32'h0000_0000;
      if (setup_acc && !pwrite)
      begin
         case (hit)
            HIT_CSR:  prdata_d = {24'h00_0000, eoc_q, speed_q, converter_on_q, full_q, ch_q};
            HIT_HIGH: prdata_d = {24'h00_0000, result_q[9:2]};
            HIT_LOW:  prdata_d = {30'h0000_0000, result_q[1:0]};
            default:  prdata_d = 32'h0000_0000;
         endcase
      end
      speed_d = speed_q;
      converter_on_d  = converter_on_q;
      full_d  = full_q;
      ch_d    = ch_q;
      if (wr_csr)
      begin
         speed_d = pwdata[CSR_SPEED_POS];
         converter_on_d  = pwdata[CSR_ON_POS];
         full_d  = pwdata[CSR_FULL_POS];
         // channel field straight to the multiplexer
         ch_d    = wdata_ch;
      end
      eoc_d = eoc_q;
      // clear on high read or control write
      if (wr_csr || rd_high)
      begin
         eoc_d = 1'b0;
      end
      if (drain)
      begin
         eoc_d = 1'b1;
      end
      result_d = drain ? buf_out_data : result_q;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         eoc_q     <= CSR_RESET[CSR_EOC_POS];
         speed_q   <= CSR_RESET[CSR_SPEED_POS];
         converter_on_q    <= CSR_RESET[CSR_ON_POS];
         full_q    <= CSR_RESET[CSR_FULL_POS];
         ch_q      <= CSR_RESET[CSR_CH_LSB +: 4];
         result_q  <= RESULT_RESET;
         prdata_q  <= 32'h0000_0000;
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
      end
      else
      begin
         eoc_q     <= eoc_d;
         speed_q   <= speed_d;
         converter_on_q    <= converter_on_d;
         full_q    <= full_d;
         ch_q      <= ch_d;
         result_q  <= result_d;
         prdata_q  <= prdata_d;
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
      end
   end

   // ***************************************************
   // Comparator synchroniser and wake settle
   // ***************************************************
   always_comb
   begin
      comp_f_d = (comp_s_q[1] == comp_s_q[2]) ? comp_s_q[2] : comp_f_q;
      if (halt_mode)
      begin
         settle_d = SETTLE_LOAD;
      end
      else if (settle_q != '0)
      begin
         settle_d = settle_q - SW'(1);
      end
      else
      begin
         settle_d = settle_q;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         comp_s_q <= 3'h0;
         comp_f_q <= 1'b0;
         settle_q <= '0;
      end
      else
      begin
         comp_s_q <= {comp_s_q[1:0], comp_in};
         comp_f_q <= comp_f_d;
         settle_q <= settle_d;
      end
   end

   // ***************************************************
   // Conversion sequencer
   // ***************************************************
   // comparator high keeps the bit under trial; low clears only that bit
   assign decided = comp_f_q ? trial_q : (trial_q & ~bit_mask(bit_q));

   always_comb
   begin
      state_d      = state_q;
      tcnt_d       = tcnt_q;
      bit_d        = bit_q;
      trial_d      = trial_q;
      buf_in_valid = 1'b0;
      case (state_q)
         ST_OFF:
         begin
            if (converter_on_q && !halt_mode && settle_q == '0)
            begin
               state_d = ST_SAMPLE;
               tcnt_d  = 3'h0;
               trial_d = 10'h000;
            end
         end
         ST_SAMPLE:
         begin
            if (tick)
            begin
               if (tcnt_q == SAMPLE_LAST)
               begin
                  state_d = ST_STEP;
                  tcnt_d  = 3'h0;
                  bit_d   = MSB_IDX;
                  trial_d = bit_mask(MSB_IDX);
               end
               else
               begin
                  tcnt_d = tcnt_q + 3'h1;
               end
            end
         end
         ST_STEP:
         begin
            // one bit per step, MSB first
            if (tick)
            begin
               if (tcnt_q == STEP_LAST)
               begin
                  tcnt_d = 3'h0;
                  if (bit_q == 4'h0)
                  begin
                     state_d = ST_PUSH;
                     trial_d = decided;
                  end
                  else
                  begin
                     bit_d   = bit_q - 4'h1;
                     trial_d = decided | bit_mask(bit_q - 4'h1);
                  end
               end
               else
               begin
                  tcnt_d = tcnt_q + 3'h1;
               end
            end
         end
         ST_PUSH:
         begin
            // hand over result, then go again
            buf_in_valid = 1'b1;
            if (buf_in_ready)
            begin
               state_d = ST_SAMPLE;
               tcnt_d  = 3'h0;
               trial_d = 10'h000;
            end
         end
         default:
         begin
            state_d = ST_OFF;
         end
      endcase
      if (restart)
      begin
         state_d = ST_SAMPLE;
         tcnt_d  = 3'h0;
         trial_d = 10'h000;
      end
      else if (abort)
      begin
         state_d = ST_OFF;
         tcnt_d  = 3'h0;
         trial_d = 10'h000;
      end
      pwr_d = (state_d != ST_OFF);
      sh_d  = (state_d == ST_SAMPLE);
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state_q <= ST_OFF;
         tcnt_q  <= 3'h0;
         bit_q   <= 4'h0;
         trial_q <= 10'h000;
         pwr_q   <= 1'b0;
         sh_q    <= 1'b0;
      end
      else
      begin
         state_q <= state_d;
         tcnt_q  <= tcnt_d;
         bit_q   <= bit_d;
         trial_q <= trial_d;
         pwr_q   <= pwr_d;
         sh_q    <= sh_d;
      end
   end

   // ***************************************************
   // Rate divider and result buffer
   // ***************************************************
   adcc_clkdiv u_div (
      .pclk    (pclk),
      .presetn (presetn),
      // Divider phase restarts at each sample entry
      .run     ((state_q != ST_OFF) && (state_q != ST_PUSH) && !restart),
      .rate    ({full_q, speed_q}),
      .tick    (tick)
   );

   // Results wait here while a result read is in progress
   assign buf_out_ready = ~rd_hold;
   assign drain         = buf_out_valid & buf_out_ready;

   adcc_buf2 #(
      .W     (RES_BITS),
      .DEPTH (2)
   ) u_buf (
      .pclk      (pclk),
      .presetn   (presetn),
      .flush     (abort),
      .in_valid  (buf_in_valid),
      .in_ready  (buf_in_ready),
      .in_data   (trial_q),
      .out_valid (buf_out_valid),
      .out_ready (buf_out_ready),
      .out_data  (buf_out_data)
   );

   assign prdata      = prdata_q;
   assign pready      = pready_q;
   assign pslverr     = pslverr_q;
   assign adc_enable  = pwr_q;
   assign channel_sel = ch_q;
   assign dac_code    = trial_q;
   assign sample_hold = sh_q;

   // ***************************************************
   // Checks
   // ***************************************************
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   eoc_set_a: assert property (
      drain |=> eoc_q && result_q == $past(buf_out_data))
      else $error("Completion did not set flag and result");
   eoc_read_clr_a: assert property (
      rd_high && !drain |=> !eoc_q)
      else $error("High result read left flag set");
   eoc_write_clr_a: assert property (
      wr_csr && !drain |=> !eoc_q)
      else $error("Control write left flag set");
   conv_off_a: assert property (
      !converter_on_q |-> state_q == ST_OFF && !adc_enable)
      else $error("Converter running while off");
   conv_repeat_a: assert property (
      state_q == ST_PUSH && buf_in_ready && !abort |=> state_q == ST_SAMPLE && tcnt_q == 3'h0)
      else $error("No back to back conversion");
   chan_switch_a: assert property (
      restart |=> state_q == ST_SAMPLE && channel_sel == $past(wdata_ch))
      else $error("Channel change did not restart");
   low_zero_a: assert property (
      setup_acc && !pwrite && hit == HIT_LOW |=> pready_q && prdata_q[31:2] == 30'h0)
      else $error("Low result upper bits not zero");
   halt_off_a: assert property (
      halt_mode |=> state_q == ST_OFF && settle_q == SETTLE_LOAD)
      else $error("Halt did not stop converter");
   sar_last_a: assert property (
      state_q == ST_STEP && bit_q == 4'h0 && tick && tcnt_q == STEP_LAST && !abort
      |=> state_q == ST_PUSH && trial_q == $past(decided))
      else $error("Last step did not finish conversion");
endmodule
`default_nettype wire

/* File: adcc_pkg.sv */
`default_nettype none
package adcc_pkg;
   // ***************************************************
   // Clock and bus
   // ***************************************************
   localparam int unsigned PCLK_PERIOD_NS = 50;
   // Register indices; byte address is four times the index
   localparam logic [9:0]  IDX_CONTROL_STATUS = 10'h070;
   localparam logic [9:0]  IDX_RESULT_HIGH    = 10'h071;
   localparam logic [9:0]  IDX_RESULT_LOW     = 10'h072;
   // Control/status field positions
   localparam int unsigned CSR_EOC_POS   = 7;
   localparam int unsigned CSR_SPEED_POS = 6;
   localparam int unsigned CSR_ON_POS    = 5;
   localparam int unsigned CSR_FULL_POS  = 4;
   localparam int unsigned CSR_CH_LSB    = 0;
   // Reset values
   localparam logic [7:0]  CSR_RESET    = 8'h00;
   localparam logic [9:0]  RESULT_RESET = 10'h000;
   // ***************************************************
   // Conversion timing
   // ***************************************************
   localparam int unsigned RES_BITS        = 10;
   localparam int unsigned SAMPLE_TICKS    = 4;
   localparam int unsigned STEP_TICKS      = 6;
   localparam int unsigned WAKE_SETTLE_NS  = 20_000;
   localparam int unsigned WAKE_SETTLE_CYC =
      (WAKE_SETTLE_NS + PCLK_PERIOD_NS - 1) / PCLK_PERIOD_NS;
   // Rate codes {full-speed, speed}
   localparam logic [1:0]  RATE_DIV4 = 2'h0;
   localparam logic [1:0]  RATE_FULL = 2'h3;
   typedef enum logic [1:0] {
      ST_OFF    = 2'b00,
      ST_SAMPLE = 2'b01,
      ST_STEP   = 2'b10,
      ST_PUSH   = 2'b11
   } adcc_state_type;
   typedef enum logic [1:0] {
      HIT_NONE = 2'b00,
      HIT_CSR  = 2'b01,
      HIT_HIGH = 2'b10,
      HIT_LOW  = 2'b11
   } adcc_hit_type;
endpackage
`default_nettype wire

/* File: adcc_clkdiv.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_clkdiv
   import adcc_pkg::*;
(
   input  wire logic       pclk,    // Bus clock
   input  wire logic       presetn, // Async reset, low
   input  wire logic       run,     // Converter active
   input  wire logic [1:0] rate,    // Full-speed and speed bits
   output logic            tick     // Converter clock enable
);
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic       tick_q;
   logic       tick_d;
   logic [1:0] last;

   always_comb
   begin
      case (rate)
         RATE_DIV4: last = 2'h3;
         RATE_FULL: last = 2'h0;
         default:   last = 2'h1;
      endcase
      cnt_d  = cnt_q;
      tick_d = 1'b0;
      // Idle: preload so the first tick lands one full period after start
      if (!run)
      begin
         cnt_d  = (last == 2'h0) ? 2'h0 : 2'h1;
         tick_d = (last == 2'h0);
      end
      else if (cnt_q >= last)
      begin
         cnt_d  = 2'h0;
         tick_d = 1'b1;
      end
      else
      begin
         cnt_d = cnt_q + 2'h1;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         cnt_q  <= 2'h0;
         tick_q <= 1'b0;
      end
      else
      begin
         cnt_q  <= cnt_d;
         tick_q <= tick_d;
      end
   end

   assign tick = tick_q;

   full_rate_a: assert property (@(posedge pclk) disable iff (!presetn)
      run && rate == RATE_FULL |=> tick_q)
      else $error("Full rate missed a tick");
   div4_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick_q && rate == RATE_DIV4 && $past(rate) == RATE_DIV4 |-> !$past(tick_q))
      else $error("Divide by four ticked twice in a row");
endmodule
`default_nettype wire

/* File: adcc_buf2.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_buf2 #(
   parameter int unsigned W     = 10,
   parameter int unsigned DEPTH = 2
) (
   input  wire logic         pclk,      // Bus clock
   input  wire logic         presetn,   // Async reset, low
   input  wire logic         flush,     // Drop all entries
   input  wire logic         in_valid,  // Word offered
   output logic              in_ready,  // Room for a word
   input  wire logic [W-1:0] in_data,   // Word in
   output logic              out_valid, // Word waiting
   input  wire logic         out_ready, // Consumer takes word
   output logic [W-1:0]      out_data   // Oldest word
);
   localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   localparam int unsigned CW = $clog2(DEPTH + 1);

   logic [W-1:0]  mem_q [DEPTH];
   logic [W-1:0]  mem_d [DEPTH];
   logic [PW-1:0] wptr_q, wptr_d, rptr_q, rptr_d;
   logic [CW-1:0] cnt_q, cnt_d;
   logic          push, pop;

   function automatic logic [PW-1:0] ptr_next(input logic [PW-1:0] p);
      return (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
   endfunction

   assign in_ready  = (cnt_q != CW'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data  = mem_q[rptr_q];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb
   begin
      mem_d  = mem_q;
      wptr_d = wptr_q;
      rptr_d = rptr_q;
      cnt_d  = cnt_q;
      if (flush)
      begin
         wptr_d = '0;
         rptr_d = '0;
         cnt_d  = '0;
      end
      else
      begin
         if (push)
         begin
            mem_d[wptr_q] = in_data;
            wptr_d        = ptr_next(wptr_q);
         end
         if (pop)
         begin
            rptr_d = ptr_next(rptr_q);
         end
         cnt_d = cnt_q + CW'(push) - CW'(pop);
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         for (int i = 0; i < DEPTH; i++)
         begin
            mem_q[i] <= '0;
         end
         wptr_q <= '0;
         rptr_q <= '0;
         cnt_q  <= '0;
      end
      else
      begin
         mem_q  <= mem_d;
         wptr_q <= wptr_d;
         rptr_q <= rptr_d;
         cnt_q  <= cnt_d;
      end
   end
endmodule
`default_nettype wire

/* File: adcc_core_model.sv */
`timescale 1ns/1ps
`default_nettype none
module adcc_core_model
(
   input  wire logic       pclk,        // Bus clock
   input  wire logic       adc_enable,  // Core powered
   input  wire logic [3:0] channel_sel, // Input select
   input  wire logic [9:0] dac_code,    // Trial word
   input  wire logic       sample_hold, // Sample switch
   output logic            comp_in      // Comparator
);
   int   level [16];
   int   held   = 0;
   logic comp_q = 1'b0;
   always @(posedge pclk)
   begin
      if (sample_hold)
         held <= level[channel_sel];
      // Unpowered comparator output wanders
      if (!adc_enable)
         comp_q <= ~comp_q;
      else
         comp_q <= (held >= int'(dac_code));
   end
   assign comp_in = comp_q;
endmodule
`default_nettype wire

/* File: adc_conversion_control_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_control_bench;
   import adcc_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, halt_mode;
   logic        comp_in, adc_enable, sample_hold, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  channel_sel, ch;
   logic [9:0]  dac_code;
   logic [1:0]  r;
   int          fails, checks, seed, n, lv, i;
   adcc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .halt_mode(halt_mode),
      .comp_in(comp_in), .adc_enable(adc_enable), .channel_sel(channel_sel),
      .dac_code(dac_code), .sample_hold(sample_hold));
   adcc_core_model core (.pclk(pclk), .adc_enable(adc_enable),
      .channel_sel(channel_sel), .dac_code(dac_code),
      .sample_hold(sample_hold), .comp_in(comp_in));
   // ******************************
   // Helpers
   // ******************************
   function automatic int div(input logic [1:0] c);
      return (c == RATE_DIV4) ? 4 : (c == RATE_FULL) ? 1 : 2;
   endfunction
   function automatic logic [9:0] sat(input int v);
      return (v > 1023) ? 10'h3ff : (v < 0) ? 10'h000 : v[9:0];
   endfunction
   task automatic end_sim();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("wrong value at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic bad();
      fails++;
      $display("wrong value at %0t: wait ran out", $time);
      end_sim();
   endtask
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [7:0] wd);
      int k;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
         if (k > 20)
            bad();
      end
      while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wait_sh(input logic v);
      int k;
      for (k = 0; sample_hold !== v; k++)
      begin
         if (k > 2000)
            bad();
         @(posedge pclk);
      end
   endtask
   task automatic poll();
      int k;
      for (k = 0; k < 200; k++)
      begin
         apb(1'b0, IDX_CONTROL_STATUS, 8'h00);
         if (rd[7] === 1'b1)
            return;
      end
      bad();
   endtask
   task automatic result(input int v);
      logic [9:0] e;
      e = sat(v);
      apb(1'b0, IDX_RESULT_LOW, 8'h00);
      chk(rd, {30'h0, e[1:0]});
      apb(1'b0, IDX_RESULT_HIGH, 8'h00);
      chk(rd, {24'h0, e[9:2]});
   endtask
   initial
   begin
      pclk = 1'b0;
      forever
         #(PCLK_PERIOD_NS / 2) pclk = ~pclk;
   end
   // ******************************
   // Main sequence
   // ******************************
   initial
   begin
      {presetn, psel, penable, pwrite, halt_mode} = 5'h0;
      paddr = 12'h000;
      pwdata = 32'h0;
      {fails, checks, seed} = {32'd0, 32'd0, 32'd76};
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      for (i = 0; i < 3; i++)
      begin
         apb(1'b0, IDX_CONTROL_STATUS + i[9:0], 8'h00);
         chk(rd, 32'h0);
      end
      apb(1'b0, 10'h073, 8'h00);
      chk(rd, 32'h0);
      chk({31'h0, err}, 32'h1);
      apb(1'b1, IDX_RESULT_HIGH, 8'hff);
      apb(1'b0, IDX_RESULT_HIGH, 8'h00);
      chk(rd, 32'h0);
      for (i = 0; i < 6; i++)
      begin
         r = i[1:0];
         ch = 4'($random(seed));
         // A new channel forces a restart on the fresh level while the converter runs; the first pass starts it from off
         if (ch == channel_sel)
            ch = ch + 4'h1;
         lv = (i == 4) ? 1100 : (i == 5) ? -5 : ($random(seed) & 1023);
         core.level[ch] = lv;
         apb(1'b1, IDX_CONTROL_STATUS, {1'b0, r[0], 1'b1, r[1], ch});
         chk({28'h0, channel_sel}, {28'h0, ch});
         wait_sh(1'b0);
         wait_sh(1'b1);
         for (n = 0; sample_hold === 1'b1 && n < 100; n++)
            @(posedge pclk);
         chk(n, SAMPLE_TICKS * div(r));
         poll();
         result(lv);
         apb(1'b0, IDX_CONTROL_STATUS, 8'h00);
         chk({31'h0, rd[7]}, 32'h0);
      end
      lv = $random(seed) & 1023;
      core.level[ch] = lv;
      poll();
      apb(1'b0, IDX_RESULT_HIGH, 8'h00);
      poll();
      result(lv);
      poll();
      apb(1'b1, IDX_CONTROL_STATUS, {4'ha, ch});
      apb(1'b0, IDX_CONTROL_STATUS, 8'h00);
      chk(rd, {24'h0, 4'h2, ch});
      wait_sh(1'b1);
      wait_sh(1'b0);
      lv = $random(seed) & 1023;
      core.level[ch + 4'h1] = lv;
      apb(1'b1, IDX_CONTROL_STATUS, {4'h2, ch + 4'h1});
      apb(1'b0, IDX_CONTROL_STATUS, 8'h00);
      chk(rd, {24'h0, 4'h2, ch + 4'h1});
      poll();
      result(lv);
      apb(1'b1, IDX_CONTROL_STATUS, 8'h00);
      n = 0;
      repeat (300)
      begin
         @(posedge pclk);
         n += (sample_hold !== 1'b0 || adc_enable !== 1'b0 || dac_code !== 10'h000);
      end
      chk(n, 0);
      apb(1'b1, IDX_CONTROL_STATUS, 8'h20);
      halt_mode <= 1'b1;
      repeat (10) @(posedge pclk);
      chk({31'h0, adc_enable}, 32'h0);
      halt_mode <= 1'b0;
      for (n = 0; sample_hold !== 1'b1 && n < 2000; n++)
         @(posedge pclk);
      chk({31'h0, (n >= WAKE_SETTLE_CYC && n < 2000)}, 32'h1);
      end_sim();
   end
endmodule
`default_nettype wire
